// ---- src/irq_ctrl_map.vh ----
// Purpose: Register offsets, field positions, reset values, timing counts
// Assumes: AHB-Lite byte addresses; one register per aligned word
// Notes: Printed offsets 0x38/0x39 are not both word multiples, so they are indices
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// Register indices (byte address is four times the index)
`define IDX_FLAGS 8'h38
`define IDX_ENABLES 8'h39
`define IDX_PIN_EN 8'h3B
`define IDX_PIN_FLAGS 8'h3A
`define IDX_CORE_CTRL 8'h35
`define IDX_STATUS 8'h3F
`define IDX_CORE_CMD 8'h40
`define IDX_VECTOR 8'h41

// Bit positions shared by enables and flags
`define BIT_T2_CMP 7
`define BIT_T2_OVF 6
`define BIT_T1_CAP 5
`define BIT_T1_CMPA 4
`define BIT_T1_CMPB 3
`define BIT_T1_OVF 2
`define BIT_RSVD 1
`define BIT_T0_OVF 0
`define TIMER_BITS_MASK 8'hFD

// External pin enable and flag positions
`define BIT_PIN_ONE 7
`define BIT_PIN_ZERO 6
`define PIN_BITS_MASK 8'hC0

// Sense field encodings
`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

// Global enable position in the core status word
`define BIT_GLOBAL_EN 7

// Core command register bits
`define CMD_INSTR_DONE 0
`define CMD_RETURN 1

// Reset values
`define RST_FLAGS 8'h00
`define RST_ENABLES 8'h00
`define RST_CTRL 8'h00
`define RST_STATUS 8'h00

// Vector addresses
`define VEC_PIN_ZERO 12'h001
`define VEC_PIN_ONE 12'h002
`define VEC_T2_CMP 12'h003
`define VEC_T2_OVF 12'h004
`define VEC_T1_CAP 12'h005
`define VEC_T1_CMPA 12'h006
`define VEC_T1_CMPB 12'h007
`define VEC_T1_OVF 12'h008
`define VEC_T0_OVF 12'h009

// Entry and return lengths in clock cycles
`define ENTRY_CYCLES 3'h4
`define RETURN_CYCLES 3'h4

`endif

// ---- src/pin_sense.v ----
// Purpose: Synchronise one external interrupt pin and detect its sense event
// Assumes: Pin is asynchronous to clock
// Notes: Level mode output follows the synchronised pin, no memory
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

module pin_sense (
    input wire clock, // System clock
    input wire srst, // Synchronous reset, active high
    input wire pinIn, // Raw pin level
    input wire [1:0] sense, // Sense selection
    output wire edgeHit, // One-cycle pulse on selected edge
    output wire levelLow // High while level mode and pin is low
);

    reg sync1_ff;
    reg sync2_ff;
    reg prev_ff;

    // Two-stage synchroniser then a history stage for edges
    always @(posedge clock) begin
        if (srst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            sync1_ff <= pinIn;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // Edge and level decode; reserved code detects nothing
    assign edgeHit = ((sense == `SENSE_FALL) && prev_ff && !sync2_ff) ||
        ((sense == `SENSE_RISE) && !prev_ff && sync2_ff);
    assign levelLow = (sense == `SENSE_LOW) && !sync2_ff;

endmodule
`default_nettype wire

// ---- src/timer_and_pin_interrupt_ctrl.v ----
// Purpose: Timer and external pin interrupt flags, enables and vectoring
// Assumes: Timers give one-cycle event pulses; core signals instruction ends
// Notes: Registers reached over AHB-Lite, one word per register
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

module timer_and_pin_interrupt_ctrl #(
    parameter SP_WIDTH = 16, // Stack pointer width
    parameter SP_RESET = 16'h00FF // Stack pointer after reset
) (
    input wire clock, // System clock, 50 MHz
    input wire srst, // Synchronous reset, active high
    input wire hsel, // AHB slave select
    input wire [31:0] haddr, // AHB address
    input wire [1:0] htrans, // AHB transfer type
    input wire hwrite, // AHB write
    input wire [2:0] hsize, // AHB size
    input wire [31:0] hwdata, // AHB write data
    input wire hready, // AHB bus ready
    output reg [31:0] hrdata, // AHB read data
    output wire hreadyout, // AHB slave ready
    output wire hresp, // AHB response, always OKAY
    input wire t2CompareMatch, // Timer-2 count equals compare value
    input wire t2Overflow, // Timer-2 normal overflow
    input wire t2PwmLeaveZero, // Timer-2 PWM count leaves 00
    input wire t2PwmMode, // Timer-2 is in PWM mode
    input wire t1CaptureDone, // Count copied to capture register
    input wire t1CompareAMatch, // Timer-1 count equals compare A
    input wire t1CompareBMatch, // Timer-1 count equals compare B
    input wire t1Overflow, // Timer-1 normal overflow
    input wire t1PwmLeaveZero, // Timer-1 PWM count leaves 0000
    input wire t1PwmMode, // Timer-1 is in PWM mode
    input wire t0Overflow, // Timer-0 overflow
    input wire extIrqPinZero, // External pin zero level
    input wire extIrqPinOne, // External pin one level
    input wire instrDone, // Core finished current instruction
    input wire [15:0] returnPc, // PC to save on entry
    input wire [15:0] poppedPc, // PC read back from stack
    input wire irqReturnInstr, // Core executes interrupt return
    output reg vectorValid, // One-cycle pulse: fetch from vectorAddr
    output reg [11:0] vectorAddr, // Vector address being taken
    output reg entryBusy, // Entry sequence in progress
    output reg returnDone, // One-cycle pulse: resume at resumePc
    output reg [15:0] resumePc, // PC restored by return
    output reg pushStrobe, // One-cycle pulse: write pushByte
    output reg [7:0] pushByte, // Byte pushed to stack
    output reg [SP_WIDTH-1:0] stackPtr, // Current stack pointer
    output wire globalEnable // Global interrupt enable
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ENTRY = 2'h1;
    localparam ST_RETURN = 2'h2;

    reg [7:0] flags_ff;
    reg [7:0] enables_ff;
    reg [7:0] pinEn_ff;
    reg [7:0] pinFlags_ff;
    reg [7:0] coreCtrl_ff;
    reg [7:0] status_ff;
    reg [1:0] state_ff;
    reg [2:0] count_ff;
    reg holdOff_ff;
    reg [3:0] srcSel_ff;
    reg [15:0] savedPc_ff;
    reg wrPend_ff;
    reg rdPend_ff;
    reg [7:0] idx_ff;

    wire pinZeroEdge;
    wire pinZeroLow;
    wire pinOneEdge;
    wire pinOneLow;

    // Pin inputs are sampled regardless of any port direction setting
    pin_sense senseZero (
        .clock(clock),
        .srst(srst),
        .pinIn(extIrqPinZero),
        .sense(coreCtrl_ff[1:0]),
        .edgeHit(pinZeroEdge),
        .levelLow(pinZeroLow)
    );
    pin_sense senseOne (
        .clock(clock),
        .srst(srst),
        .pinIn(extIrqPinOne),
        .sense(coreCtrl_ff[3:2]),
        .edgeHit(pinOneEdge),
        .levelLow(pinOneLow)
    );

    // Word index of an AHB byte address
    function [7:0] wordIndex;
        input [31:0] addr;
        begin
            wordIndex = addr[9:2];
        end
    endfunction

    // Priority encoder over nine sources, lower vector first
    function [3:0] pickSource;
        input [8:0] req;
        integer i;
        begin
            pickSource = 4'hF;
            for (i = 8; i >= 0; i = i - 1) begin
                if (req[i]) begin
                    pickSource = i[3:0];
                end
            end
        end
    endfunction

    // AHB address phase capture
    wire addrPhase = hsel && htrans[1] && hready;
    always @(posedge clock) begin
        if (srst) begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            idx_ff <= 8'h00;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            rdPend_ff <= addrPhase && !hwrite;
            idx_ff <= wordIndex(haddr);
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire wrFlags = wrPend_ff && (idx_ff == `IDX_FLAGS);
    wire wrEnables = wrPend_ff && (idx_ff == `IDX_ENABLES);
    wire wrPinEn = wrPend_ff && (idx_ff == `IDX_PIN_EN);
    wire wrPinFlags = wrPend_ff && (idx_ff == `IDX_PIN_FLAGS);
    wire wrCtrl = wrPend_ff && (idx_ff == `IDX_CORE_CTRL);
    wire wrStatus = wrPend_ff && (idx_ff == `IDX_STATUS);
    wire [7:0] wd = hwdata[7:0];

    // Requests: sources 0..8 map to vectors 001..009
    wire gie = status_ff[`BIT_GLOBAL_EN];
    wire [8:0] pending;
    assign pending[0] = pinEn_ff[`BIT_PIN_ZERO] &&
        (pinFlags_ff[`BIT_PIN_ZERO] || pinZeroLow);
    assign pending[1] = pinEn_ff[`BIT_PIN_ONE] &&
        (pinFlags_ff[`BIT_PIN_ONE] || pinOneLow);
    assign pending[2] = enables_ff[`BIT_T2_CMP] && flags_ff[`BIT_T2_CMP];
    assign pending[3] = enables_ff[`BIT_T2_OVF] && flags_ff[`BIT_T2_OVF];
    assign pending[4] = enables_ff[`BIT_T1_CAP] && flags_ff[`BIT_T1_CAP];
    assign pending[5] = enables_ff[`BIT_T1_CMPA] &&
        flags_ff[`BIT_T1_CMPA];
    assign pending[6] = enables_ff[`BIT_T1_CMPB] &&
        flags_ff[`BIT_T1_CMPB];
    assign pending[7] = enables_ff[`BIT_T1_OVF] && flags_ff[`BIT_T1_OVF];
    assign pending[8] = enables_ff[`BIT_T0_OVF] && flags_ff[`BIT_T0_OVF];

    // Accept only at an instruction boundary, idle, global on, not held off
    wire take = (state_ff == ST_IDLE) && gie && (|pending) && instrDone &&
        !holdOff_ff;
    wire [3:0] src = pickSource(pending);
    wire vecFire = (state_ff == ST_ENTRY) && (count_ff == `ENTRY_CYCLES - 3'h1);
    wire retStart = (state_ff == ST_IDLE) && irqReturnInstr && !take;
    wire retEnd = (state_ff == ST_RETURN) &&
        (count_ff == `RETURN_CYCLES - 3'h1);

    // Hardware event sets per flag; PWM mode picks the leave-zero event
    wire [7:0] hwSet;
    assign hwSet[`BIT_T2_CMP] = t2CompareMatch;
    assign hwSet[`BIT_T2_OVF] = t2PwmMode ? t2PwmLeaveZero : t2Overflow;
    assign hwSet[`BIT_T1_CAP] = t1CaptureDone;
    assign hwSet[`BIT_T1_CMPA] = t1CompareAMatch;
    assign hwSet[`BIT_T1_CMPB] = t1CompareBMatch;
    assign hwSet[`BIT_T1_OVF] = t1PwmMode ? t1PwmLeaveZero : t1Overflow;
    assign hwSet[`BIT_RSVD] = 1'b0;
    assign hwSet[`BIT_T0_OVF] = t0Overflow;

    // Hardware clear when the vector is taken, one-hot on the flag bit
    reg [7:0] vecClr;
    reg [7:0] pinVecClr;
    always @* begin
        vecClr = 8'h00;
        pinVecClr = 8'h00;
        if (vecFire) begin
            case (srcSel_ff)
                4'h0: pinVecClr[`BIT_PIN_ZERO] = 1'b1;
                4'h1: pinVecClr[`BIT_PIN_ONE] = 1'b1;
                4'h2: vecClr[`BIT_T2_CMP] = 1'b1;
                4'h3: vecClr[`BIT_T2_OVF] = 1'b1;
                4'h4: vecClr[`BIT_T1_CAP] = 1'b1;
                4'h5: vecClr[`BIT_T1_CMPA] = 1'b1;
                4'h6: vecClr[`BIT_T1_CMPB] = 1'b1;
                4'h7: vecClr[`BIT_T1_OVF] = 1'b1;
                4'h8: vecClr[`BIT_T0_OVF] = 1'b1;
                default: vecClr = 8'h00;
            endcase
        end
    end

    // Flag registers: set beats clear; reserved bit forced zero
    wire [7:0] swClr = wrFlags ? wd : 8'h00;
    wire [7:0] nxt_flags = (hwSet | (flags_ff & ~(swClr | vecClr))) &
        `TIMER_BITS_MASK;
    wire [7:0] pinSet = {pinOneEdge, pinZeroEdge, 6'h00};
    wire [7:0] pinSwClr = wrPinFlags ? wd : 8'h00;
    // Level mode keeps no pin flag
    wire [7:0] pinLevelClr = {coreCtrl_ff[3:2] == `SENSE_LOW,
        coreCtrl_ff[1:0] == `SENSE_LOW, 6'h00};
    wire [7:0] nxt_pinFlags = (pinSet |
        (pinFlags_ff & ~(pinSwClr | pinVecClr))) & ~pinLevelClr &
        `PIN_BITS_MASK;

    // Register file updates
    always @(posedge clock) begin
        if (srst) begin
            flags_ff <= `RST_FLAGS;
            enables_ff <= `RST_ENABLES;
            pinEn_ff <= `RST_ENABLES;
            pinFlags_ff <= `RST_FLAGS;
            coreCtrl_ff <= `RST_CTRL;
            status_ff <= `RST_STATUS;
        end else begin
            flags_ff <= nxt_flags;
            pinFlags_ff <= nxt_pinFlags;
            if (wrEnables) begin
                enables_ff <= wd & `TIMER_BITS_MASK;
            end
            if (wrPinEn) begin
                pinEn_ff <= wd & `PIN_BITS_MASK;
            end
            if (wrCtrl) begin
                coreCtrl_ff <= wd & 8'h7F;
            end
            if (take) begin
                status_ff[`BIT_GLOBAL_EN] <= 1'b0;
            end else if (retEnd) begin
                status_ff[`BIT_GLOBAL_EN] <= 1'b1;
            end else if (wrStatus) begin
                status_ff <= wd;
            end
        end
    end
    assign globalEnable = gie;

    // Entry and return sequencer
    always @(posedge clock) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            count_ff <= 3'h0;
            srcSel_ff <= 4'h0;
            savedPc_ff <= 16'h0000;
            holdOff_ff <= 1'b0;
            stackPtr <= SP_RESET[SP_WIDTH-1:0];
            vectorValid <= 1'b0;
            vectorAddr <= 12'h000;
            entryBusy <= 1'b0;
            returnDone <= 1'b0;
            resumePc <= 16'h0000;
            pushStrobe <= 1'b0;
            pushByte <= 8'h00;
        end else begin
            vectorValid <= 1'b0;
            returnDone <= 1'b0;
            pushStrobe <= 1'b0;
            if (instrDone && (state_ff == ST_IDLE)) begin
                holdOff_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    count_ff <= 3'h0;
                    if (take) begin
                        state_ff <= ST_ENTRY;
                        srcSel_ff <= src;
                        savedPc_ff <= returnPc;
                        entryBusy <= 1'b1;
                    end else if (retStart) begin
                        state_ff <= ST_RETURN;
                    end
                end
                ST_ENTRY: begin
                    count_ff <= count_ff + 3'h1;
                    // Push low then high byte, SP down one per byte
                    if (count_ff == 3'h0 || count_ff == 3'h1) begin
                        pushStrobe <= 1'b1;
                        pushByte <= (count_ff == 3'h0) ? savedPc_ff[7:0] :
                            savedPc_ff[15:8];
                        stackPtr <= stackPtr - 1'b1;
                    end
                    if (vecFire) begin
                        state_ff <= ST_IDLE;
                        entryBusy <= 1'b0;
                        vectorValid <= 1'b1;
                        vectorAddr <= {8'h00, srcSel_ff} + 12'h001;
                    end
                end
                ST_RETURN: begin
                    count_ff <= count_ff + 3'h1;
                    if (count_ff == 3'h0 || count_ff == 3'h1) begin
                        stackPtr <= stackPtr + 1'b1;
                    end
                    if (retEnd) begin
                        state_ff <= ST_IDLE;
                        returnDone <= 1'b1;
                        resumePc <= poppedPc;
                        holdOff_ff <= 1'b1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Read data, decoded combinationally in the data phase
    always @* begin
        hrdata = 32'h00000000;
        if (rdPend_ff) begin
            if (idx_ff == `IDX_FLAGS) begin
                hrdata = {24'h000000, flags_ff};
            end else if (idx_ff == `IDX_ENABLES) begin
                hrdata = {24'h000000, enables_ff};
            end else if (idx_ff == `IDX_PIN_EN) begin
                hrdata = {24'h000000, pinEn_ff};
            end else if (idx_ff == `IDX_PIN_FLAGS) begin
                hrdata = {24'h000000, pinFlags_ff};
            end else if (idx_ff == `IDX_CORE_CTRL) begin
                hrdata = {24'h000000, coreCtrl_ff};
            end else if (idx_ff == `IDX_STATUS) begin
                hrdata = {24'h000000, status_ff};
            end else if (idx_ff == `IDX_VECTOR) begin
                hrdata = {20'h00000, vectorAddr};
            end
        end
    end

endmodule
`default_nettype wire

// ---- verification/irq_ctrl_checker.sv ----
// Purpose: Entry and return timing checks for the interrupt controller
// Assumes: Bound to the controller top, one clock domain
// Notes: Stack pointer figures assume one nesting level per entry
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker #(
    parameter SP_WIDTH = 16
) (
    input wire clock, // System clock
    input wire srst, // Synchronous reset
    input wire instrDone, // Core boundary
    input wire [15:0] returnPc, // PC offered for saving
    input wire irqReturnInstr, // Return start
    input wire vectorValid, // Vector pulse
    input wire entryBusy, // Entry running
    input wire returnDone, // Return finished
    input wire pushStrobe, // Push pulse
    input wire [7:0] pushByte, // Pushed byte
    input wire [SP_WIDTH-1:0] stackPtr, // Stack pointer
    input wire globalEnable // Global enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Byte halves of the saved PC
    wire [7:0] pcLo = returnPc[7:0];
    wire [7:0] pcHi = returnPc[15:8];
    // Two pushes, then quiet
    sequence s_push;
        pushStrobe ##1 pushStrobe ##1 !pushStrobe;
    endsequence
    // Low byte first, high byte second
    sequence s_bytes;
        pushByte == $past(pcLo, 2) ##1 pushByte == $past(pcHi, 3);
    endsequence
    property p_entry_len;
        $rose(entryBusy) |-> !vectorValid [*4] ##1 vectorValid;
    endproperty
    a_entry_len: assert property (p_entry_len)
        else $error("vector not four cycles after take");
    property p_entry_push;
        $rose(entryBusy) |-> ##1 s_push;
    endproperty
    a_entry_push: assert property (p_entry_push)
        else $error("entry push count wrong");
    property p_entry_bytes;
        $rose(entryBusy) |-> ##1 s_bytes;
    endproperty
    a_entry_bytes: assert property (p_entry_bytes)
        else $error("pushed bytes wrong");
    property p_entry_sp;
        $rose(entryBusy) |-> ##2 stackPtr == $past(stackPtr, 3) - 2;
    endproperty
    a_entry_sp: assert property (p_entry_sp)
        else $error("stack pointer not lowered by two");
    property p_take_gate;
        $rose(entryBusy) |-> $past(globalEnable) && $past(instrDone);
    endproperty
    a_take_gate: assert property (p_take_gate)
        else $error("entry without global enable or boundary");
    property p_gie_off;
        vectorValid |-> !globalEnable && !entryBusy;
    endproperty
    a_gie_off: assert property (p_gie_off)
        else $error("global enable still set at vector");
    property p_ret_len;
        returnDone |-> $past(irqReturnInstr, 5) && globalEnable;
    endproperty
    a_ret_len: assert property (p_ret_len)
        else $error("return not four cycles or enable not set");
    property p_ret_sp;
        returnDone |-> stackPtr == $past(stackPtr, 4) + 2;
    endproperty
    a_ret_sp: assert property (p_ret_sp)
        else $error("stack pointer not raised by two");
    property p_ret_hold;
        returnDone |=> !entryBusy;
    endproperty
    a_ret_hold: assert property (p_ret_hold)
        else $error("entry right after return");
endmodule
bind timer_and_pin_interrupt_ctrl irq_ctrl_checker #(
    .SP_WIDTH(SP_WIDTH)
) chk (.clock(clock), .srst(srst), .instrDone(instrDone),
    .returnPc(returnPc), .irqReturnInstr(irqReturnInstr),
    .vectorValid(vectorValid), .entryBusy(entryBusy),
    .returnDone(returnDone), .pushStrobe(pushStrobe),
    .pushByte(pushByte), .stackPtr(stackPtr),
    .globalEnable(globalEnable));
`default_nettype wire

// ---- verification/core_model.sv ----
// Purpose: Processor core that supplies the return PC and keeps the stack bytes
// Assumes: Bench commands stalls and returns
// Notes: Popped PC is scrambled outside a return
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic stall, // Hold a multi-cycle instruction
    input wire logic retReq, // Start a return
    input wire logic pushStrobe, // Push pulse
    input wire logic [7:0] pushByte, // Pushed byte
    input wire logic returnDone, // Return finished
    output logic instrDone, // Boundary
    output logic [15:0] returnPc, // PC to save
    output logic [15:0] poppedPc, // PC read from stack
    output logic irqReturnInstr // Return pulse
);
    logic [15:0] savedPc_ff;
    logic retOn_ff;
    // No boundary while an instruction is held
    assign instrDone = !stall;
    // Stack bytes only visible during a return
    assign poppedPc = retOn_ff ? savedPc_ff : ~savedPc_ff;
    // Stack capture and program counter
    always @(posedge clock) begin
        if (srst) begin
            savedPc_ff <= 16'h0000;
            retOn_ff <= 1'b0;
            irqReturnInstr <= 1'b0;
            returnPc <= 16'hA5C3;
        end else begin
            irqReturnInstr <= retReq;
            if (pushStrobe) begin
                savedPc_ff <= {pushByte, savedPc_ff[15:8]};
            end
            if (irqReturnInstr) begin
                retOn_ff <= 1'b1;
            end
            if (returnDone) begin
                retOn_ff <= 1'b0;
                returnPc <= returnPc + 16'h0111;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Register, flag, priority and pin tests of the controller
// Assumes: Bus slave answers at once; core model at the far side
// Notes: Stack pointer starts at SPR
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"
module testbench;
    localparam logic [15:0] SPR = 16'h00FF;
    logic clock = 1'b0, srst, hsel, hwrite, stall, retReq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, pwm, pins;
    logic [2:0] hsize;
    logic [8:0] ev;
    logic hreadyout, hresp, vectorValid, entryBusy, returnDone;
    logic pushStrobe, instrDone, irqReturnInstr, globalEnable;
    logic [11:0] vectorAddr;
    logic [15:0] resumePc, stackPtr, returnPc, poppedPc;
    logic [7:0] pushByte;
    int mismatches = 0, checksDone = 0, vecCount = 0;
    timer_and_pin_interrupt_ctrl #(.SP_WIDTH(16), .SP_RESET(SPR)) dut (
        .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .t2CompareMatch(ev[0]), .t2Overflow(ev[1]),
        .t2PwmLeaveZero(ev[2]), .t2PwmMode(pwm[0]), .t1CaptureDone(ev[3]),
        .t1CompareAMatch(ev[4]), .t1CompareBMatch(ev[5]),
        .t1Overflow(ev[6]), .t1PwmLeaveZero(ev[7]), .t1PwmMode(pwm[1]),
        .t0Overflow(ev[8]), .extIrqPinZero(pins[0]),
        .extIrqPinOne(pins[1]), .instrDone(instrDone),
        .returnPc(returnPc), .poppedPc(poppedPc),
        .irqReturnInstr(irqReturnInstr), .vectorValid(vectorValid),
        .vectorAddr(vectorAddr), .entryBusy(entryBusy),
        .returnDone(returnDone), .resumePc(resumePc),
        .pushStrobe(pushStrobe), .pushByte(pushByte),
        .stackPtr(stackPtr), .globalEnable(globalEnable));
    core_model core (.clock(clock), .srst(srst), .stall(stall),
        .retReq(retReq), .pushStrobe(pushStrobe), .pushByte(pushByte),
        .returnDone(returnDone), .instrDone(instrDone),
        .returnPc(returnPc), .poppedPc(poppedPc),
        .irqReturnInstr(irqReturnInstr));
    // Clock at 50 MHz
    always #10 clock = ~clock;
    // Count vectors taken
    always @(posedge clock) begin
        if (vectorValid === 1'b1) vecCount <= vecCount + 1;
    end
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single-word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
        check("hresp", hresp, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic rdchk(input string n, input logic [7:0] idx,
        input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        check(n, r, exp);
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 9'h000;
    endtask
    task automatic pin(input int p, input logic v);
        @(posedge clock);
        pins[p] <= v;
        repeat (3) @(posedge clock);
    endtask
    // No vector over twenty cycles
    task automatic quiet;
        int k;
        k = vecCount;
        repeat (20) @(posedge clock);
        check("vecCount", vecCount, k);
    endtask
    // Await a vector, then run a return with the core held or free
    task automatic take(input logic [11:0] v, input logic hold);
        int n;
        n = 0;
        @(posedge clock);
        while (vectorValid !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check("vectorValid", vectorValid, 32'h1);
        check("vectorAddr", {20'h0, vectorAddr}, {20'h0, v});
        check("globalEnable", globalEnable, 32'h0);
        check("stackPtr", stackPtr, SPR - 16'h0002);
        retReq <= 1'b1;
        stall <= hold;
        @(posedge clock);
        retReq <= 1'b0;
        n = 0;
        while (returnDone !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check("returnDone", returnDone, 32'h1);
        check("resumePc", resumePc, returnPc);
        check("globalEnable", globalEnable, 32'h1);
        check("stackPtr", stackPtr, SPR);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog: the tests need about 500 cycles
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    initial begin
        srst = 1'b1;
        {hsel, hwrite, stall, retReq} = 4'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, pwm, hsize, ev} = 16'h0;
        pins = 2'h3;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        rdchk("flags", `IDX_FLAGS, 32'h00);
        rdchk("enables", `IDX_ENABLES, 32'h00);
        wr(`IDX_ENABLES, 8'hFF);
        rdchk("enables", `IDX_ENABLES, 32'hFD);
        wr(`IDX_ENABLES, 8'h00);
        $display("test registers done");
        pwm <= 2'h3;
        pulse(9'h042);
        rdchk("flags", `IDX_FLAGS, 32'h00);
        pulse(9'h084);
        rdchk("flags", `IDX_FLAGS, 32'h44);
        wr(`IDX_FLAGS, 8'h04);
        rdchk("flags", `IDX_FLAGS, 32'h40);
        wr(`IDX_FLAGS, 8'hFF);
        pwm <= 2'h0;
        pulse(9'h17B);
        rdchk("flags", `IDX_FLAGS, 32'hFD);
        wr(`IDX_ENABLES, 8'hFD);
        quiet();
        stall <= 1'b1;
        wr(`IDX_STATUS, 8'h80);
        quiet();
        stall <= 1'b0;
        for (int v = 3; v <= 9; v++) begin
            take(v[11:0], 1'b0);
        end
        rdchk("flags", `IDX_FLAGS, 32'h00);
        $display("test priority done");
        wr(`IDX_ENABLES, 8'h00);
        pulse(9'h100);
        quiet();
        rdchk("flags", `IDX_FLAGS, 32'h01);
        wr(`IDX_ENABLES, 8'h01);
        take(`VEC_T0_OVF, 1'b0);
        rdchk("vector", `IDX_VECTOR, {20'h0, `VEC_T0_OVF});
        $display("test masking done");
        wr(`IDX_PIN_EN, 8'hC0);
        for (int p = 0; p < 2; p++) begin
            wr(`IDX_CORE_CTRL, 8'h02 << (2 * p));
            pin(p, 1'b0);
            take(p + 1, 1'b0);
            wr(`IDX_CORE_CTRL, 8'h03 << (2 * p));
            pin(p, 1'b1);
            take(p + 1, 1'b0);
            wr(`IDX_CORE_CTRL, 8'h01 << (2 * p));
            pin(p, 1'b0);
            pin(p, 1'b1);
            quiet();
            wr(`IDX_CORE_CTRL, 8'h00);
            pin(p, 1'b0);
            take(p + 1, 1'b0);
            take(p + 1, 1'b1);
            pin(p, 1'b1);
            stall <= 1'b0;
            quiet();
        end
        $display("test pins done");
        final_report();
    end
endmodule
`default_nettype wire
